// File: hw/dpl_locator.v
// Purpose: decimal point locator: k and result counters, point code output
// Assumes: all inputs synchronous to ref_clk; clocks are one-cycle enables
// Notes: point code pins are two-way; oe low means this block drives
//
// Overview of operation
// R01 - in display cycle, divide k-locator clock by eight into display strobe
// R02 - display strobe clocks scalers and denominator data out slowly
// R03 - k counter decrements per k clock while result below k, stops equal
// R04 - result counter steps on its clock; direction high down, low up
// R05 - self-ranging select low in auto, high when manual position chosen
// R06 - aligned flag goes low once point aligned in auto display
// R07 - ranging qualifier aligns continuously in auto, once per manual reset
// R08 - one-shot ranging request raised on manual non-remote reset
// R09 - drive point code normally; accept plug-in code on same lines
// R10 - active-low preset command sets all locator counter outputs high
// R11 - manual mode steps result counter until equal to panel position
// R12 - fewer-than-three-digits holds point and multiplier in place
// R13 - reset clears strobe divider for deterministic phase
`timescale 1ns/1ps
`include "dpl_consts.vh"
module dpl_locator (
  input  wire                    ref_clk,
  input  wire                    rst_b,
  input  wire                    display_cycle,
  input  wire                    k_locator_clock,
  input  wire                    result_locator_clock,
  input  wire                    locator_count_down,
  input  wire                    result_locator_preset_b,
  input  wire                    k_locator_preset_b,
  input  wire                    plugin_point_select_b,
  input  wire [`DPL_CODE_W-1:0]  point_position_code_in,
  input  wire [`DPL_PANEL_W-1:0] panel_point_position,
  input  wire                    one_shot_ranging_request,
  input  wire                    fewer_than_three_digits,
  output reg  [`DPL_CODE_W-1:0]  point_position_code_out,
  output wire                    point_position_code_oe,
  output wire                    slow_display_strobe,
  output reg                     self_ranging_select,
  output reg                     combined_ranging_qualifier,
  output reg                     point_aligned_flag,
  output reg                     k_sign,
  output reg  [`DPL_POS_W-1:0]   k_locator_count,
  output reg  [`DPL_POS_W-1:0]   result_locator_count
);
  // decoded qualifiers, combinational off registered state and pins
  wire                    manual_mode;
  wire                    auto_run;
  wire                    hold;
  wire                    k_step;
  wire                    k_behind;
  wire                    codes_equal;
  wire [`DPL_PANEL_W-1:0] result_low;
  wire                    panel_equal;
  wire                    result_above_panel;

  // next values of every register of this module
  reg  [`DPL_POS_W-1:0]   next_k_locator_count;
  reg                     next_k_sign;
  reg  [`DPL_POS_W-1:0]   next_result_locator_count;
  reg  [`DPL_CODE_W-1:0]  next_point_position_code_out;
  reg                     next_self_ranging_select;
  reg                     next_combined_ranging_qualifier;
  reg                     next_point_aligned_flag;

  // one step of a locator counter; wraps as a plain binary counter
  // would, so the sequencer must not clock past either end
  function [`DPL_POS_W-1:0] step_pos;
    input [`DPL_POS_W-1:0] pos;
    input                  down;
    begin
      if (down) begin
        step_pos = pos - `DPL_POS_ONE;
      end else begin
        step_pos = pos + `DPL_POS_ONE;
      end
    end
  endfunction

  // the panel reserves one code for automatic ranging
  function is_manual;
    input [`DPL_PANEL_W-1:0] code;
    begin
      is_manual = (code != `DPL_PANEL_AUTO);
    end
  endfunction

  assign manual_mode = is_manual(panel_point_position); // R05
  // one-shot request forces a single auto pass while in manual
  assign auto_run    = !manual_mode || one_shot_ranging_request; // R07 R08
  assign hold        = fewer_than_three_digits; // R12
  assign k_behind    = (result_locator_count < k_locator_count); // R03
  assign codes_equal = (result_locator_count == k_locator_count); // R06
  // manual chase only looks at the low bits against the four-line code
  assign result_low  = result_locator_count[`DPL_PANEL_W-1:0];
  assign panel_equal = (result_low == panel_point_position); // R11
  assign result_above_panel = (result_low > panel_point_position); // R11

  // the divider only sees k clocks inside the display cycle
  assign k_step = k_locator_clock && display_cycle; // R01

  dpl_strobe_div u_div (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .step    (k_step),
    .strobe  (slow_display_strobe) // R02
  );

  // release the lines while the plug-in supplies the point code
  assign point_position_code_oe = !plugin_point_select_b; // R09

  // k counter: preset beats plug-in load beats the clock
  always @* begin
    next_k_locator_count = k_locator_count;
    if (!k_locator_preset_b) begin
      next_k_locator_count = `DPL_POS_ONES; // R10
    end else if (!plugin_point_select_b) begin
      next_k_locator_count = point_position_code_in[`DPL_POS_W-1:0]; // R09
    end else if (k_locator_clock && !display_cycle && !hold) begin
      // stops by itself once both codes agree
      if (k_behind) begin
        next_k_locator_count = step_pos(k_locator_count, `DPL_BIT_HIGH);
      end
    end
  end

  // sign of the k counter follows the same priority, but never counts
  always @* begin
    next_k_sign = k_sign;
    if (!k_locator_preset_b) begin
      next_k_sign = `DPL_SIGN_ONE; // R10
    end else if (!plugin_point_select_b) begin
      next_k_sign = point_position_code_in[`DPL_CODE_W-1]; // R09
    end
  end

  // result counter: auto follows the direction line, manual chases panel
  always @* begin
    next_result_locator_count = result_locator_count;
    if (!result_locator_preset_b) begin
      next_result_locator_count = `DPL_POS_ONES; // R10
    end else if (result_locator_clock && !hold) begin
      if (auto_run) begin
        next_result_locator_count = step_pos(result_locator_count,
                                             locator_count_down); // R04
      end else if (!panel_equal) begin
        // in manual the direction line is ignored
        next_result_locator_count = step_pos(result_locator_count,
                                             result_above_panel); // R11
      end
    end
  end

  // status outputs are registered; point code and aligned flag trail the counters by one edge
  always @* begin
    next_point_position_code_out    = {k_sign, k_locator_count}; // R09
    next_self_ranging_select        = manual_mode; // R05
    next_combined_ranging_qualifier = auto_run; // R07
    next_point_aligned_flag         = `DPL_BIT_HIGH;
    if (auto_run && (hold || codes_equal)) begin
      next_point_aligned_flag = `DPL_BIT_LOW; // R06 R12
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      k_locator_count <= `DPL_POS_ONES;
    end else begin
      k_locator_count <= next_k_locator_count; // R03
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      k_sign <= `DPL_SIGN_ONE;
    end else begin
      k_sign <= next_k_sign;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      result_locator_count <= `DPL_POS_ONES;
    end else begin
      result_locator_count <= next_result_locator_count;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      point_position_code_out <= `DPL_CODE_ONES;
    end else begin
      point_position_code_out <= next_point_position_code_out;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      self_ranging_select <= `DPL_BIT_LOW;
    end else begin
      self_ranging_select <= next_self_ranging_select;
    end
  end

  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      combined_ranging_qualifier <= `DPL_BIT_LOW;
    end else begin
      combined_ranging_qualifier <= next_combined_ranging_qualifier;
    end
  end

  // high after reset: nothing counts as aligned until the first clock edge out of reset
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      point_aligned_flag <= `DPL_BIT_HIGH;
    end else begin
      point_aligned_flag <= next_point_aligned_flag;
    end
  end
endmodule

// File: hw/dpl_consts.vh
// Purpose: shared constants for the point locator block
// Assumes: 10 MHz ref_clk, plain Verilog-2005
// Notes: widths and reset codes live here only
`ifndef DPL_CONSTS_VH
`define DPL_CONSTS_VH
`define DPL_POS_W        5
`define DPL_CODE_W       6
`define DPL_PANEL_W      4
`define DPL_DIV_W        3
`define DPL_POS_ONES     5'h1F
`define DPL_SIGN_ONE     1'h1
`define DPL_DIV_ZERO     3'h0
`define DPL_DIV_LAST     3'h7
`define DPL_PANEL_AUTO   4'hF
`define DPL_POS_ONE      5'h01
`define DPL_DIV_ONE      3'h1
`define DPL_CODE_ONES    6'h3F
`define DPL_BIT_LOW      1'h0
`define DPL_BIT_HIGH     1'h1
`endif

// File: hw/dpl_strobe_div.v
// Purpose: divide-by-eight of the k-locator clock into the display strobe
// Assumes: step is a one-cycle enable pulse on ref_clk
// Notes: cleared by reset so the strobe phase is known
`timescale 1ns/1ps
`include "dpl_consts.vh"
module dpl_strobe_div (
  input  wire ref_clk,
  input  wire rst_b,
  input  wire step,
  output reg  strobe
);
  reg [`DPL_DIV_W-1:0] count;
  always @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      count  <= `DPL_DIV_ZERO; // R13
      strobe <= `DPL_BIT_LOW;
    end else begin
      strobe <= `DPL_BIT_LOW;
      if (step) begin
        count <= count + `DPL_DIV_ONE; // R01
        if (count == `DPL_DIV_LAST)
          strobe <= `DPL_BIT_HIGH; // R01
      end
    end
  end
endmodule

// File: test/dpl_seq_model.sv
// Purpose: sequencer stand-in holding locator clock enables high for as many cycles as pick is set
// Assumes: silent between bursts. Notes: pick sampled on falling edge
`timescale 1ns/1ps
module dpl_seq_model (input wire ref_clk, input wire [1:0] pick,
  output reg kc = 1'h0, output reg rc = 1'h0);
  always @(negedge ref_clk) {rc, kc} <= pick;
endmodule

// File: test/dpl_locator_asserts.sv
// Purpose: port checks for the point locator
// Assumes: one clock. Notes: flag timing left to the bench
`timescale 1ns/1ps
module dpl_locator_asserts (input wire ref_clk, rst_b, display_cycle,
  k_locator_clock, result_locator_clock, locator_count_down, k_sign,
  result_locator_preset_b, k_locator_preset_b, plugin_point_select_b,
  fewer_than_three_digits, slow_display_strobe, point_position_code_oe,
  input wire [3:0] panel_point_position,
  input wire [4:0] k_locator_count, result_locator_count);
  wire h = result_locator_preset_b & k_locator_preset_b
    & plugin_point_select_b;
  wire g = h & !fewer_than_three_digits;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_strobe_pulse: assert property (slow_display_strobe |->
    $past(k_locator_clock & display_cycle) ##1 !slow_display_strobe)
    else $error("strobe");
  a_k_preset: assert property (!k_locator_preset_b |=> k_sign
    && k_locator_count == 5'h1F) else $error("k preset");
  a_r_preset: assert property (!result_locator_preset_b |=>
    result_locator_count == 5'h1F) else $error("r preset");
  a_hold_still: assert property (h & fewer_than_three_digits |=>
    $stable({k_locator_count, result_locator_count})) else $error("hold");
  a_r_step: assert property (g & result_locator_clock
    & panel_point_position == 4'hF |=> result_locator_count ==
    $past(result_locator_count) + ($past(locator_count_down) ? 5'h1F
    : 5'h01)) else $error("r step");
  a_k_step: assert property (g & k_locator_clock & !display_cycle
    |=> k_locator_count == $past(k_locator_count)
    - $past(result_locator_count < k_locator_count)) else $error("k step");
  a_k_display: assert property (g & display_cycle |=>
    $stable(k_locator_count)) else $error("k in display");
  a_oe_follow: assert property (point_position_code_oe ==
    !plugin_point_select_b) else $error("oe");
endmodule
bind dpl_locator dpl_locator_asserts chk (.*);

// File: test/dpl_locator_tb.sv
// Purpose: self-checking bench for the point locator
// Assumes: falling-edge drive. Notes: notes queued, monitor compares
`timescale 1ns/1ps
module dpl_locator_tb;
  reg ref_clk = 1'h0, rst_b = 1'h0, disp = 1'h0, dn = 1'h0, few = 1'h0;
  reg pb = 1'h1, pi_b = 1'h1, os = 1'h0, ef = 1'h0;
  reg [1:0] pick = 2'h0;
  reg [3:0] es = 4'h0, stb = 4'h0, pnl = 4'hF;
  reg [5:0] ek = 6'h3F;
  reg [4:0] er = 5'h1F;
  reg [31:0] rs = 14665;
  integer bad_count = 0, checks = 0, i;
  reg [24:0] q[$];
  wire kc, rc, ks, st, oe, sel, qual, al;
  wire [4:0] kl, rl;
  wire [5:0] pc;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) stb <= stb + {3'h0, st};
  always @(negedge ref_clk) if (q.size() > 0)
    chk({stb, ks, kl, rl, pc, oe, sel, qual, al}, q.pop_front());
  dpl_seq_model seq (.ref_clk, .pick, .kc, .rc);
  dpl_locator dut (.ref_clk, .rst_b, .display_cycle(disp),
    .k_locator_clock(kc), .result_locator_clock(rc),
    .locator_count_down(dn), .result_locator_preset_b(pb),
    .k_locator_preset_b(pb), .plugin_point_select_b(pi_b),
    .point_position_code_in(rs[5:0]), .panel_point_position(pnl),
    .one_shot_ranging_request(os), .fewer_than_three_digits(few),
    .point_position_code_out(pc), .point_position_code_oe(oe),
    .slow_display_strobe(st), .self_ranging_select(sel),
    .combined_ranging_qualifier(qual), .point_aligned_flag(al), .k_sign(ks),
    .k_locator_count(kl), .result_locator_count(rl));
  task chk(input [24:0] s, input [24:0] e);
    checks = checks + 1;
    if (s !== e) begin
      bad_count = bad_count + 1;
      $display("unexpected state exp %h seen %h", e, s);
    end
  endtask
  task want;
    // aligned flag is low in an auto pass once codes agree or on hold
    ef = !((pnl == 4'hF || os) && (few || er == ek[4:0]));
    q.push_back({es, ek, er, ek, !pi_b, pnl != 4'hF, pnl == 4'hF || os,
      ef});
    @(negedge ref_clk) $display("test done");
  endtask
  // pulses start one falling edge after pick is set, as the sequencer does
  task run(input [1:0] p, input [4:0] c);
    pick <= p;
    repeat (c) @(negedge ref_clk);
    pick <= 2'h0;
    repeat (4) @(negedge ref_clk);
  endtask
  task close_out;
    // let the monitor drain the last note before judging
    repeat (2) @(negedge ref_clk);
    if (q.size() != 0) bad_count = bad_count + 1;
    $display("checks %0d bad %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    rst_b <= 1'h1;
    run(2'h0, 5'h01);
    want;
    for (i = 0; i < 6; i = i + 1) begin
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      dn <= rs[0];
      er = rs[0] ? er - rs[3:1] - 5'h01 : er + rs[3:1] + 5'h01;
      run(2'h2, rs[3:1] + 5'h01);
      want;
    end
    few <= 1'h1;
    run(2'h3, 5'h03);
    want;
    few <= 1'h0;
    pb <= 1'h0;
    @(negedge ref_clk) pb <= 1'h1;
    dn <= 1'h1;
    run(2'h2, 5'h04);
    er = 5'h1B;
    want;
    run(2'h1, 5'h08);
    ek = 6'h3B;
    want;
    pi_b <= 1'h0;
    ek = rs[5:0];
    run(2'h1, 5'h02);
    want;
    pi_b <= 1'h1;
    disp <= 1'h1;
    run(2'h1, 5'h17);
    es = 4'h2;
    want;
    run(2'h1, 5'h01);
    es = 4'h3;
    want;
    disp <= 1'h0;
    pnl <= 4'h3;
    run(2'h2, 5'h0A);
    er = 5'h13;
    want;
    os <= 1'h1;
    dn <= 1'h0;
    run(2'h2, 5'h02);
    er = 5'h15;
    want;
    os <= 1'h0;
    pnl <= 4'hF;
    close_out;
  end
endmodule
